// file: verilog/eefe_regs.svh
// Constants for the two-wire EEPROM bus front end
//
// Overview of operation
// RULE1: Main store is 8192 byte-wide locations, 64 kilobits in all.
// RULE2: Optional 32-byte identification page, permanently lockable to read-only; the code clears the lock at power-on reset.
// RULE3: Serial clock captures incoming bits and paces outgoing bits.
// RULE4: Data line is open drain: pull low or release only.
// RULE5: Strap inputs must equal select bits b3..b1 for the device to answer.
// RULE6: An unconnected strap input counts as zero.
// RULE7: Five-ball variant uses fixed straps 0,0,1 instead of pins.
// RULE8: Write-inhibit high blocks all array writes; low or open allows them.
// RULE9: Under write-inhibit, select and address bytes acked, data bytes not.
// RULE10: Ignore the bus until power-on reset releases, then enter standby.
// RULE11: Power-on reset asserting again stops all bus responses.
// RULE12: A decoded stop enters standby unless a write cycle runs.
// RULE13: Device is always target; master starts transfers and supplies clock.
// RULE14: Start is data falling with clock high, watched except during writes.
// RULE15: Master sends a start before any instruction.
// RULE16: Stop is data rising with clock high; it ends communication.
// RULE17: Master ends a read with no-ack then stop; device goes standby.
// RULE18: A stop ending a write instruction begins the internal write cycle.
// RULE19: Receiving, the device samples data on each rising clock edge.
// RULE20: Master changes data only while clock is low, except start/stop.
// RULE21: Sender releases data after bit eight; receiver pulls low on ninth.
// RULE22: Last select bit picks direction: one reads, zero writes.
// RULE23: Select mismatch: release bus, no acknowledge, back to standby.
// RULE24: During the write cycle the output stays off and nothing is answered.
// RULE25: Select type code 1011 addresses the identification page.
// RULE26: Lines are synchronised and edge-detected into one-cycle events.
// RULE27: A start mid-transfer abandons the byte and awaits a new select byte.
`ifndef EEFE_REGS_SVH
`define EEFE_REGS_SVH

`define EEFE_MEM_DEPTH    8192
`define EEFE_ID_DEPTH     32
`define EEFE_TYPE_MEM     4'hA
`define EEFE_TYPE_ID      4'hB
`define EEFE_STRAP_FIXED  3'h1
`define EEFE_LAST_BIT     4'h7
`define EEFE_ACK_SLOT     4'h8
`define EEFE_LOCK_ADDR    10
`define EEFE_LOCK_DATA    1
`define EEFE_CLK_NS       25
`define EEFE_TW_NS        5000000
`define EEFE_TW_CYC       (`EEFE_TW_NS / `EEFE_CLK_NS)

`endif

// file: verilog/eefe_pkg.sv
// Types shared by the two-wire EEPROM bus front end
package eefe_pkg;

  typedef enum logic [2:0] {
    EEFE_IDLE   = 3'h0,
    EEFE_DEVSEL = 3'h1,
    EEFE_ADDR_H = 3'h2,
    EEFE_ADDR_L = 3'h3,
    EEFE_WDATA  = 3'h4,
    EEFE_RDATA  = 3'h5,
    EEFE_BUSY   = 3'h6
  } eefe_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } eefe_line_t;

endpackage

// file: verilog/eefe_front_end.sv
// Bus front end and storage of a serial two-wire EEPROM target
`include "eefe_regs.svh"

module eefe_front_end #(
  parameter int TW_CYC       = `EEFE_TW_CYC,
  parameter bit FIXED_STRAPS = 1'b0
)(
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       scl,
  input  wire logic       sda_line,
  output logic            sda_level,
  output logic            sda_oe,
  input  wire logic [2:0] chip_select_straps,
  input  wire logic       write_inhibit_in,
  output logic            standby,
  output logic            write_busy
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic                    rst_m_q;
  logic                    rst_n_q;
  logic                    bit_val_q;
  logic                    bit_tgl_q;
  eefe_pkg::eefe_line_t    line_m_q;
  eefe_pkg::eefe_line_t    line_s_q;
  eefe_pkg::eefe_line_t    line_p_q;
  logic [2:0]              strap_m_q;
  logic [2:0]              strap_s_q;
  logic                    wp_m_q;
  logic                    wp_s_q;
  logic                    tgl_m_q;
  logic                    tgl_s_q;
  logic                    tgl_p_q;
  eefe_pkg::eefe_state_t   state_q;
  logic [3:0]              bit_q;
  logic [6:0]              shift_q;
  logic                    ack_q;
  logic                    id_sel_q;
  logic                    rd_first_q;
  logic                    arm_q;
  logic [15:0]             addr_q;
  logic [31:0]             pv_q;
  logic                    lock_req_q;
  logic                    lock_q;
  logic [7:0]              tx_q;
  logic [5:0]              wi_q;
  logic [17:0]             tw_q;
  logic                    oe_q;
  logic [7:0]              mem [`EEFE_MEM_DEPTH];
  logic [7:0]              id_mem [`EEFE_ID_DEPTH];
  logic [7:0]              page_q [`EEFE_ID_DEPTH];
  logic                    start_ev;
  logic                    stop_ev;
  logic                    scl_fall;
  logic                    bit_ev;
  logic                    byte_done;
  logic                    ack_slot;
  logic                    rx_bit;
  logic [7:0]              byte_in;
  logic [2:0]              straps;
  logic                    sel_match;
  logic                    wr_ok;
  logic                    commit_we;
  logic [7:0]              rd_byte;

  ////////////////////////////////////////////////////////////////////////////////
  // Power-on reset release

  // Assertion is immediate so the bus is dropped at once on power-down
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q; // [RULE10] [RULE11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain: the serial clock itself captures each data bit

  // The master keeps data steady across the rising edge, so no synchroniser here
  always_ff @(posedge scl or negedge nrst)
  begin
    if (!nrst)
    begin
      bit_val_q <= 1'b0;
      bit_tgl_q <= 1'b0;
    end
    else
    begin
      bit_val_q <= sda_line;   // [RULE19] [RULE20] [RULE3]
      bit_tgl_q <= ~bit_tgl_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronisers into the system clock

  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      line_m_q  <= '{scl: 1'b1, sda: 1'b1};
      line_s_q  <= '{scl: 1'b1, sda: 1'b1};
      line_p_q  <= '{scl: 1'b1, sda: 1'b1};
      strap_m_q <= 3'h0;
      strap_s_q <= 3'h0;
      wp_m_q    <= 1'b0;
      wp_s_q    <= 1'b0;
      tgl_m_q   <= 1'b0;
      tgl_s_q   <= 1'b0;
      tgl_p_q   <= 1'b0;
    end
    else
    begin
      line_m_q  <= '{scl: scl, sda: sda_line}; // [RULE26]
      line_s_q  <= line_m_q;
      line_p_q  <= line_s_q;
      strap_m_q <= chip_select_straps;
      strap_s_q <= strap_m_q;
      wp_m_q    <= write_inhibit_in;
      wp_s_q    <= wp_m_q;
      tgl_m_q   <= bit_tgl_q;
      tgl_s_q   <= tgl_m_q;
      tgl_p_q   <= tgl_s_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One-cycle bus events

  assign start_ev  = line_s_q.scl & line_p_q.scl & line_p_q.sda & ~line_s_q.sda; // [RULE14] [RULE26]
  assign stop_ev   = line_s_q.scl & line_p_q.scl & ~line_p_q.sda & line_s_q.sda; // [RULE16] [RULE26]
  assign scl_fall  = line_p_q.scl & ~line_s_q.scl;
  assign bit_ev    = tgl_s_q ^ tgl_p_q; // [RULE26]
  // Captured bit is held for a full clock period, long after the toggle lands
  assign rx_bit    = bit_val_q;
  assign byte_in   = {shift_q, rx_bit};
  assign byte_done = bit_ev & (bit_q == `EEFE_LAST_BIT);
  assign ack_slot  = bit_ev & (bit_q == `EEFE_ACK_SLOT);

  // Open straps are pulled to zero at the pad, so an open pin reads as 0
  assign straps    = FIXED_STRAPS ? `EEFE_STRAP_FIXED : strap_s_q; // [RULE6] [RULE7]
  assign sel_match = ((byte_in[7:4] == `EEFE_TYPE_MEM) || (byte_in[7:4] == `EEFE_TYPE_ID))
                     && (byte_in[3:1] == straps); // [RULE5]
  // An open inhibit pin is pulled low at the pad, which allows writes
  assign wr_ok     = ~wp_s_q & ~(id_sel_q & lock_q); // [RULE8] [RULE2]
  assign rd_byte   = id_sel_q ? id_mem[addr_q[4:0]] : mem[addr_q[12:0]];

  ////////////////////////////////////////////////////////////////////////////////
  // Protocol state

  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q    <= eefe_pkg::EEFE_IDLE; // [RULE10]
      ack_q      <= 1'b0;
      id_sel_q   <= 1'b0;
      rd_first_q <= 1'b0;
      arm_q      <= 1'b0;
    end
    else if (state_q == eefe_pkg::EEFE_BUSY)
    begin
      if (tw_q == 18'h00000)
        state_q <= eefe_pkg::EEFE_IDLE; // [RULE24]
    end
    else if (start_ev)
    begin
      state_q <= eefe_pkg::EEFE_DEVSEL; // [RULE14] [RULE15] [RULE27]
      ack_q   <= 1'b0;
      arm_q   <= 1'b0;
    end
    else if (stop_ev)
    begin
      ack_q <= 1'b0;
      arm_q <= 1'b0;
      if (arm_q && bit_q == 4'h1 && state_q == eefe_pkg::EEFE_WDATA)
        state_q <= eefe_pkg::EEFE_BUSY; // [RULE18]
      else
        state_q <= eefe_pkg::EEFE_IDLE; // [RULE12] [RULE16] [RULE17]
    end
    else if (byte_done)
    begin
      unique case (state_q)
        eefe_pkg::EEFE_IDLE:
        begin
          ack_q <= 1'b0;
        end
        eefe_pkg::EEFE_DEVSEL:
        begin
          if (sel_match)
          begin
            ack_q    <= 1'b1; // [RULE21]
            id_sel_q <= (byte_in[7:4] == `EEFE_TYPE_ID); // [RULE25]
            if (byte_in[0])
            begin
              state_q    <= eefe_pkg::EEFE_RDATA; // [RULE22]
              rd_first_q <= 1'b1;
            end
            else
              state_q <= eefe_pkg::EEFE_ADDR_H;
          end
          else
          begin
            ack_q   <= 1'b0; // [RULE23]
            state_q <= eefe_pkg::EEFE_IDLE;
          end
        end
        eefe_pkg::EEFE_ADDR_H:
        begin
          ack_q   <= 1'b1; // [RULE9]
          state_q <= eefe_pkg::EEFE_ADDR_L;
        end
        eefe_pkg::EEFE_ADDR_L:
        begin
          ack_q   <= 1'b1; // [RULE9]
          state_q <= eefe_pkg::EEFE_WDATA;
        end
        eefe_pkg::EEFE_WDATA:
        begin
          ack_q <= wr_ok; // [RULE9]
          arm_q <= wr_ok;
        end
        eefe_pkg::EEFE_RDATA:
        begin
          ack_q <= 1'b0; // [RULE21]
        end
        eefe_pkg::EEFE_BUSY:
        begin
          ack_q <= 1'b0;
        end
      endcase
    end
    else if (ack_slot && state_q == eefe_pkg::EEFE_RDATA)
    begin
      rd_first_q <= 1'b0;
      if (!rd_first_q && rx_bit)
        state_q <= eefe_pkg::EEFE_IDLE; // [RULE17]
    end
    else if (bit_ev && bit_q != 4'h0 && bit_q < `EEFE_LAST_BIT)
      arm_q <= 1'b0; // Stop needs a clock pulse of its own: the ninth and tenth slots keep the arm
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bit counter and shifter

  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      bit_q   <= 4'h0;
      shift_q <= 7'h00;
    end
    else if (state_q == eefe_pkg::EEFE_BUSY || start_ev || stop_ev)
      bit_q <= 4'h0; // [RULE27]
    else if (bit_ev)
    begin
      bit_q   <= (bit_q == `EEFE_ACK_SLOT) ? 4'h0 : bit_q + 4'h1;
      shift_q <= byte_in[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address, page latch and read data

  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      addr_q     <= 16'h0000;
      pv_q       <= 32'h00000000;
      lock_req_q <= 1'b0;
      tx_q       <= 8'hFF;
    end
    else if (state_q == eefe_pkg::EEFE_BUSY)
    begin
      pv_q <= pv_q;
    end
    else if (byte_done)
    begin
      unique case (state_q)
        eefe_pkg::EEFE_DEVSEL:
        begin
          if (sel_match && !byte_in[0])
          begin
            pv_q       <= 32'h00000000;
            lock_req_q <= 1'b0;
          end
        end
        eefe_pkg::EEFE_ADDR_H:
          addr_q[15:8] <= byte_in;
        eefe_pkg::EEFE_ADDR_L:
          addr_q[7:0] <= byte_in;
        eefe_pkg::EEFE_WDATA:
        begin
          if (wr_ok)
          begin
            if (id_sel_q && addr_q[`EEFE_LOCK_ADDR])
              lock_req_q <= byte_in[`EEFE_LOCK_DATA]; // [RULE2]
            else
            begin
              pv_q[addr_q[4:0]] <= 1'b1;
              addr_q[4:0]       <= addr_q[4:0] + 5'h01; // Rolls over inside the page
            end
          end
        end
        default:
        begin
          pv_q <= pv_q;
        end
      endcase
    end
    else if (ack_slot && state_q == eefe_pkg::EEFE_RDATA && (rd_first_q || !rx_bit))
    begin
      tx_q   <= rd_byte;
      addr_q <= addr_q + 16'h0001;
    end
  end

  // Page data needs no reset: the valid mask decides what is committed
  always_ff @(posedge sys_clk)
  begin
    if (byte_done && state_q == eefe_pkg::EEFE_WDATA && wr_ok)
      page_q[addr_q[4:0]] <= byte_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Internal write cycle

  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      wi_q   <= 6'h00;
      tw_q   <= 18'h00000;
      lock_q <= 1'b0;
    end
    else if (state_q != eefe_pkg::EEFE_BUSY)
    begin
      wi_q <= 6'h00;
      tw_q <= 18'(TW_CYC - 1);
    end
    else
    begin
      if (!wi_q[5])
        wi_q <= wi_q + 6'h01;
      if (tw_q != 18'h00000)
        tw_q <= tw_q - 18'h00001;
      if (wi_q == 6'h00 && lock_req_q)
        lock_q <= 1'b1; // [RULE2]
    end
  end

  assign commit_we = (state_q == eefe_pkg::EEFE_BUSY) & ~wi_q[5] & pv_q[wi_q[4:0]];

  // One page byte per cycle; the whole page lands well inside the write time
  always_ff @(posedge sys_clk)
  begin
    if (commit_we)
    begin
      if (id_sel_q)
        id_mem[wi_q[4:0]] <= page_q[wi_q[4:0]]; // [RULE2] [RULE25]
      else
        mem[{addr_q[12:5], wi_q[4:0]}] <= page_q[wi_q[4:0]]; // [RULE1]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data line drive, set on the falling serial clock and released at once in standby or during a write cycle

  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      oe_q <= 1'b0; // [RULE11]
    else if (state_q == eefe_pkg::EEFE_IDLE || state_q == eefe_pkg::EEFE_BUSY)
      oe_q <= 1'b0; // [RULE23] [RULE24]
    else if (scl_fall)
    begin
      if (bit_q == `EEFE_ACK_SLOT)
        oe_q <= ack_q; // [RULE21]
      else if (state_q == eefe_pkg::EEFE_RDATA)
        oe_q <= ~tx_q[3'(`EEFE_LAST_BIT - bit_q)]; // [RULE3]
      else
        oe_q <= 1'b0;
    end
  end

  // Never drives high and never drives the clock: the master owns both
  assign sda_level  = 1'b0; // [RULE4] [RULE13]
  assign sda_oe     = oe_q;
  assign standby    = (state_q == eefe_pkg::EEFE_IDLE); // [RULE12]
  assign write_busy = (state_q == eefe_pkg::EEFE_BUSY);

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  busy_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q) // [RULE24]
    (state_q == eefe_pkg::EEFE_BUSY) |=> !sda_oe)
    else $error("Data line driven during write cycle");

  stop_standby_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q) // [RULE12]
    (stop_ev && state_q != eefe_pkg::EEFE_BUSY && !(arm_q && bit_q == 4'h1))
    |=> (state_q == eefe_pkg::EEFE_IDLE) && standby)
    else $error("Stop did not return to standby");

  stop_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q) // [RULE18]
    (stop_ev && arm_q && bit_q == 4'h1 && state_q == eefe_pkg::EEFE_WDATA)
    |=> write_busy ##1 write_busy)
    else $error("Stop after data ack did not start write cycle");

  start_restart_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q) // [RULE27]
    (start_ev && state_q != eefe_pkg::EEFE_BUSY)
    |=> (state_q == eefe_pkg::EEFE_DEVSEL) && (bit_q == 4'h0))
    else $error("Start did not restart select reception");

  inhibit_nack_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q) // [RULE9]
    (byte_done && state_q == eefe_pkg::EEFE_WDATA && wp_s_q) |=> !ack_q && !arm_q)
    else $error("Data byte acknowledged under write inhibit");

  mismatch_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q) // [RULE23]
    (byte_done && state_q == eefe_pkg::EEFE_DEVSEL && !start_ev && !stop_ev && !sel_match)
    |=> (state_q == eefe_pkg::EEFE_IDLE) ##1 !sda_oe)
    else $error("Mismatched select byte not released");

  ack_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q) // [RULE21]
    (scl_fall && bit_q == `EEFE_ACK_SLOT && ack_q && !stop_ev && !start_ev
     && state_q != eefe_pkg::EEFE_IDLE && state_q != eefe_pkg::EEFE_BUSY) |=> sda_oe)
    else $error("Acknowledge not driven in ninth slot");

  busy_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q) // [RULE24]
    $rose(write_busy) |-> write_busy [*8])
    else $error("Write cycle ended too early");

  bit_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q) // [RULE26]
    bit_ev |=> !bit_ev)
    else $error("Bit event longer than one cycle");

  id_select_a: assert property (@(posedge sys_clk) disable iff (!rst_n_q) // [RULE25]
    (byte_done && state_q == eefe_pkg::EEFE_DEVSEL && !start_ev && !stop_ev && sel_match)
    |=> (id_sel_q == $past(byte_in[4])))
    else $error("Identification page select wrong");

endmodule

// file: verification/eefe_mst_model.sv
// Two-wire bus master model that clocks the bus and pulls the data wire
module eefe_mst_model (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda_line
);
  timeunit 1ns;
  timeprecision 100ps;

  // Quarter bit time; slow enough for the synchroniser in the system domain
  localparam int QTR = 160;

  // Clock idles high and stands still between frames
  initial
  begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Only the master begins a transfer and supplies the clock
  task automatic start_cond();
    sda_pull = 1'b0;
    #QTR;
    scl = 1'b1;
    #(2*QTR);
    sda_pull = 1'b1;
    #(2*QTR);
    scl = 1'b0;
  endtask

  task automatic stop_cond();
    #QTR;
    sda_pull = 1'b1;
    #QTR;
    scl = 1'b1;
    #(2*QTR);
    sda_pull = 1'b0;
    #(2*QTR);
  endtask

  // Data changes only while clock is low
  task automatic clock_bit(input logic bit_out, output logic bit_in);
    #QTR;
    sda_pull = ~bit_out;
    #QTR;
    scl = 1'b1;
    #QTR;
    bit_in = sda_line;
    #QTR;
    scl = 1'b0;
  endtask

  // Release after the eighth bit, ninth slot carries the answer
  task automatic write_byte(input logic [7:0] data, output logic acked);
    logic b;
    for (int i = 7; i >= 0; i--)
      clock_bit(data[i], b);
    clock_bit(1'b1, b);
    acked = ~b;
  endtask

  // Last byte answered with no acknowledge before a stop
  task automatic read_byte(input logic last, output logic [7:0] data);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      clock_bit(1'b1, b);
      data[i] = b;
    end
    clock_bit(last, b);
  endtask
endmodule

// file: verification/tb.sv
// Self-checking testbench for the two-wire EEPROM bus front end
`include "eefe_regs.svh"

module tb;
  timeunit 1ns;
  timeprecision 100ps;

  // Long enough to poll the device while its write cycle runs
  localparam int TW = 800;

  logic       sys_clk;
  logic       nrst;
  logic       scl;
  logic       sda_pull;
  logic       sda_line;
  logic       sda_level;
  logic       sda_oe;
  logic [2:0] chip_select_straps;
  logic       write_inhibit_in;
  logic       standby;
  logic       write_busy;
  logic       fix_level;
  logic       fix_oe;
  logic       fix_standby;
  int         mismatches;
  int         num_checks;
  int         cycles;

  // Pull-up on the wire: low when any party pulls
  assign sda_line = ~sda_pull & (sda_oe ? sda_level : 1'b1) & (fix_oe ? fix_level : 1'b1);

  eefe_front_end #(
    .TW_CYC       (TW),
    .FIXED_STRAPS (1'b0)
  ) dut_u (
    .sys_clk            (sys_clk),
    .nrst               (nrst),
    .scl                (scl),
    .sda_line           (sda_line),
    .sda_level          (sda_level),
    .sda_oe             (sda_oe),
    .chip_select_straps (chip_select_straps),
    .write_inhibit_in   (write_inhibit_in),
    .standby            (standby),
    .write_busy         (write_busy)
  );

  // Second target with its strap pins ignored; it answers only select bits 001
  eefe_front_end #(
    .TW_CYC       (TW),
    .FIXED_STRAPS (1'b1)
  ) fix_u (
    .sys_clk            (sys_clk),
    .nrst               (nrst),
    .scl                (scl),
    .sda_line           (sda_line),
    .sda_level          (fix_level),
    .sda_oe             (fix_oe),
    .chip_select_straps (chip_select_straps),
    .write_inhibit_in   (write_inhibit_in),
    .standby            (fix_standby),
    .write_busy         ()
  );

  eefe_mst_model mst_u (
    .scl      (scl),
    .sda_pull (sda_pull),
    .sda_line (sda_line)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Hang guard, well above the few hundred microseconds the tests need
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic set_addr(input logic [3:0] kind, input logic [15:0] addr);
    logic ack;
    mst_u.start_cond();
    mst_u.write_byte({kind, chip_select_straps, 1'b0}, ack);
    check("select ack", 8'(ack), 8'h01);
    mst_u.write_byte(addr[15:8], ack);
    check("addr hi ack", 8'(ack), 8'h01);
    mst_u.write_byte(addr[7:0], ack);
    check("addr lo ack", 8'(ack), 8'h01);
  endtask

  task automatic write_one(input logic [3:0] kind, input logic [15:0] addr, input logic [7:0] data,
                           input logic inh);
    logic ack;
    @(posedge sys_clk);
    #2 write_inhibit_in = inh;
    set_addr(kind, addr);
    mst_u.write_byte(data, ack);
    check("data ack", 8'(ack), {7'h00, ~inh});
    mst_u.stop_cond();
    check("write busy", 8'(write_busy), {7'h00, ~inh});
    check("standby at stop", 8'(standby), 8'(inh));
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (write_busy === 1'b1 && n < 2 * TW)
    begin
      @(posedge sys_clk);
      n++;
    end
    #2;
    check("write ends", 8'(write_busy), 8'h00);
    check("standby after write", 8'(standby), 8'h01);
  endtask

  task automatic read_one(input logic [3:0] kind, input logic [15:0] addr, input logic [7:0] exp);
    logic       ack;
    logic [7:0] data;
    set_addr(kind, addr);
    mst_u.start_cond();
    mst_u.write_byte({kind, chip_select_straps, 1'b1}, ack);
    check("read select ack", 8'(ack), 8'h01);
    mst_u.read_byte(1'b1, data);
    check("read data", data, exp);
    mst_u.stop_cond();
    check("standby after read", 8'(standby), 8'h01);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Write, poll while busy, then read back
  task automatic test_write_read();
    logic ack;
    write_one(`EEFE_TYPE_MEM, 16'h0123, 8'h5A, 1'b0);
    mst_u.start_cond();
    mst_u.write_byte({`EEFE_TYPE_MEM, chip_select_straps, 1'b0}, ack);
    check("poll while busy", 8'(ack), 8'h00);
    mst_u.stop_cond();
    check("still busy", 8'(write_busy), 8'h01);
    wait_done();
    read_one(`EEFE_TYPE_MEM, 16'h0123, 8'h5A);
  endtask

  // Inhibited write leaves the location alone
  task automatic test_inhibit();
    write_one(`EEFE_TYPE_MEM, 16'h0123, 8'hA5, 1'b1);
    @(posedge sys_clk);
    #2 write_inhibit_in = 1'b0;
    read_one(`EEFE_TYPE_MEM, 16'h0123, 8'h5A);
  endtask

  // Straps driven to zero select the device; code 010 is not answered, while 001 is answered by the fixed-strap target
  task automatic test_straps();
    logic ack;
    @(posedge sys_clk);
    #2 chip_select_straps = 3'h0;
    repeat (4) @(posedge sys_clk);
    #2;
    read_one(`EEFE_TYPE_MEM, 16'h0123, 8'h5A);
    mst_u.start_cond();
    mst_u.write_byte({`EEFE_TYPE_MEM, 3'h2, 1'b0}, ack);
    check("mismatch ack", 8'(ack), 8'h00);
    check("mismatch standby", 8'(standby), 8'h01);
    mst_u.stop_cond();
    mst_u.start_cond();
    mst_u.write_byte({`EEFE_TYPE_MEM, 3'h1, 1'b0}, ack);
    check("fixed straps ack", 8'(ack), 8'h01);
    mst_u.stop_cond();
    check("fixed standby", 8'(fix_standby), 8'h01);
    @(posedge sys_clk);
    #2 chip_select_straps = 3'h5;
    repeat (4) @(posedge sys_clk);
  endtask

  // Identification page is a separate store
  task automatic test_id_page();
    write_one(`EEFE_TYPE_ID, 16'h0007, 8'h3C, 1'b0);
    wait_done();
    read_one(`EEFE_TYPE_ID, 16'h0007, 8'h3C);
  endtask

  // Reset in mid-transfer silences the device
  task automatic test_reset_mid();
    logic ack;
    mst_u.start_cond();
    @(posedge sys_clk);
    #2 nrst = 1'b0;
    mst_u.write_byte({`EEFE_TYPE_MEM, chip_select_straps, 1'b0}, ack);
    check("ack in reset", 8'(ack), 8'h00);
    check("standby in reset", 8'(standby), 8'h01);
    mst_u.stop_cond();
    @(posedge sys_clk);
    #2 nrst = 1'b1;
    repeat (10) @(posedge sys_clk);
    #2;
  endtask

  // A start after three stray bits begins a fresh select byte
  task automatic test_restart();
    logic b;
    mst_u.start_cond();
    repeat (3) mst_u.clock_bit(1'b1, b);
    read_one(`EEFE_TYPE_MEM, 16'h0123, 8'h5A);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mismatches         = 0;
    num_checks         = 0;
    nrst               = 1'b0;
    chip_select_straps = 3'h5;
    write_inhibit_in   = 1'b0;
    repeat (5) @(posedge sys_clk);
    #2 nrst = 1'b1;
    repeat (10) @(posedge sys_clk);
    check("standby out of reset", 8'(standby), 8'h01);
    check("busy out of reset", 8'(write_busy), 8'h00);
    check("oe out of reset", 8'(sda_oe), 8'h00);
    check("level held low", 8'(sda_level), 8'h00);
    test_write_read();
    test_inhibit();
    test_straps();
    test_id_page();
    test_reset_mid();
    test_restart();
    report_and_stop();
  end
endmodule
